//--- rtl/fsc_device.sv
// fail-safe system mode controller, device end
`timescale 1ns/1ps
module fsc_device
  import fsc_pkg::*;
#(
  parameter int unsigned RST_SHORT = RST_SHORT_CYC,
  parameter int unsigned RST_LONG  = RST_LONG_CYC,
  parameter int unsigned RESTART_D = RESTART_CYC,
  parameter int unsigned INT_RESP  = INT_RESP_CYC,
  parameter int unsigned WD_INIT   = WD_INIT_CYC
) (
  input  wire logic   clk,
  input  wire logic   rst_b,
  input  wire logic   ce,
  fsc_link_if.device  link,
  input  wire logic   reset_length_select,
  input  wire logic   can_wake,
  input  wire logic   lin_wake,
  input  wire logic   local_wake,
  input  wire logic   osc_ok,
  input  wire logic   supply_ok,
  input  wire logic   severe_fault,
  input  wire logic   wd_fail,
  input  wire logic   int_event,
  output logic        mcu_supply_output,
  output logic        can_tx_enable,
  output logic        lin_tx_enable,
  output logic        inhibit_limphome_output,
  output logic        enable_output
);
  fsc_mode_type       mode_r;
  fsc_mode_type       mode_nxt;
  logic [CNT_W-1:0]   cnt_r;
  logic [CNT_W-1:0]   cnt_nxt;
  logic [CNT_W-1:0]   int_cnt_r;
  logic               long_r;
  logic               long_nxt;
  logic               in_reset_r;  // lengthening phase of start-up/restart
  logic               in_reset_nxt;
  logic               from_restart_r;
  logic               from_restart_nxt;
  logic               int_pend_r;
  logic [3:0]         rsrc_r;
  logic [3:0]         rsrc_nxt;
  logic               rst_out_r;
  logic               can_s, lin_s, wake_s, osc_bad_s, sup_s;

  // pins from outside the clock domain
  fsc_sync u_sync_can  (.clk(clk), .rst_b(rst_b), .ce(ce),
                        .d(can_wake),   .q(can_s));
  fsc_sync u_sync_lin  (.clk(clk), .rst_b(rst_b), .ce(ce),
                        .d(lin_wake),   .q(lin_s));
  fsc_sync u_sync_wake (.clk(clk), .rst_b(rst_b), .ce(ce),
                        .d(local_wake), .q(wake_s));
  // oscillator synced as a fault flag: the flop's reset of zero then
  // reads as a good oscillator, so no fail-safe entry follows reset
  fsc_sync u_sync_osc  (.clk(clk), .rst_b(rst_b), .ce(ce),
                        .d(!osc_ok),    .q(osc_bad_s));
  fsc_sync u_sync_sup  (.clk(clk), .rst_b(rst_b), .ce(ce),
                        .d(supply_ok),  .q(sup_s));

  // decoded conditions
  wire any_wake   = can_s | lin_s | wake_s;
  wire valid_wake = any_wake & !osc_bad_s;
  wire running    = (mode_r == FSC_NORMAL) | (mode_r == FSC_FLASH);
  wire [CNT_W-1:0] len_cyc = long_r ? CNT_W'(RST_LONG)
                                    : CNT_W'(RST_SHORT);
  wire len_done   = (cnt_r >= len_cyc - CNT_W'(1));
  wire init_tmo   = (cnt_r >= CNT_W'(WD_INIT) - CNT_W'(1));
  wire int_tmo    = int_pend_r &
                    (int_cnt_r >= CNT_W'(INT_RESP) - CNT_W'(1));
  wire wd_trip    = running & wd_fail;
  wire sys_reset  = wd_trip | int_tmo;
  wire fatal      = osc_bad_s | severe_fault;

  // mode transition logic
  always_comb begin
    mode_nxt         = mode_r;
    cnt_nxt          = cnt_r + CNT_W'(1);
    long_nxt         = long_r;
    in_reset_nxt     = in_reset_r;
    from_restart_nxt = from_restart_r;
    rsrc_nxt         = rsrc_r;
    if (fatal && mode_r != FSC_FAILSAFE) begin
      mode_nxt = FSC_FAILSAFE;
      cnt_nxt  = '0;
      rsrc_nxt = RSRC_FAILSAFE;
    end else if (sys_reset) begin
      mode_nxt         = FSC_STARTUP;
      cnt_nxt          = '0;
      in_reset_nxt     = 1'b1;
      long_nxt         = reset_length_select;
      from_restart_nxt = 1'b0;
      rsrc_nxt         = wd_trip ? RSRC_WD_FAIL : RSRC_INT_TMO;
    end else begin
      unique case (mode_r)
        FSC_STARTUP, FSC_RESTART: begin
          if (in_reset_r) begin
            if (len_done) begin
              in_reset_nxt = 1'b0;
              cnt_nxt      = '0;
            end
          end else if (mode_r == FSC_RESTART && !sup_s) begin
            mode_nxt = FSC_FAILSAFE;
            cnt_nxt  = '0;
            rsrc_nxt = RSRC_FAILSAFE;
          end else if (link.wd_init_done) begin
            // restart may only lead to normal mode
            mode_nxt = (from_restart_r || link.wd_select == 1'b0)
                       ? FSC_NORMAL : FSC_FLASH;
            cnt_nxt  = '0;
          end else if (init_tmo) begin
            cnt_nxt          = '0;
            in_reset_nxt     = 1'b1;
            if (from_restart_r) begin
              mode_nxt = FSC_FAILSAFE;
              rsrc_nxt = RSRC_FAILSAFE;
            end else begin
              mode_nxt         = FSC_RESTART;
              long_nxt         = 1'b1;
              from_restart_nxt = 1'b1;
              rsrc_nxt         = RSRC_RESTART;
            end
          end
        end
        FSC_FAILSAFE: begin
          // wake only counts to start the restart delay; once started it runs on
          // a failing oscillator also cancels a restart delay in progress
          if (osc_bad_s || (!valid_wake && cnt_r == '0)) begin
            cnt_nxt = '0;
          end else if (cnt_r >= CNT_W'(RESTART_D) - CNT_W'(1)) begin
            mode_nxt         = FSC_STARTUP;
            cnt_nxt          = '0;
            in_reset_nxt     = 1'b1;
            long_nxt         = 1'b1;
            from_restart_nxt = 1'b0;
            rsrc_nxt         = RSRC_WAKE;
          end
        end
        FSC_NORMAL, FSC_FLASH: begin
          cnt_nxt = cnt_r;
        end
      endcase
    end
  end

  // mode state and counters
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r         <= FSC_STARTUP;
      cnt_r          <= '0;
      long_r         <= 1'b0;
      in_reset_r     <= 1'b1;
      from_restart_r <= 1'b0;
      rsrc_r         <= RSRC_POWER_ON;
    end else if (ce) begin
      mode_r         <= mode_nxt;
      cnt_r          <= cnt_nxt;
      long_r         <= long_nxt;
      in_reset_r     <= in_reset_nxt;
      from_restart_r <= from_restart_nxt;
      rsrc_r         <= rsrc_nxt;
    end
  end

  // interrupt supervision; a new event wins over the host's ack
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_pend_r <= 1'b0;
      int_cnt_r  <= '0;
    end else if (ce) begin
      if (!running || sys_reset) begin
        int_pend_r <= 1'b0;
        int_cnt_r  <= '0;
      end else if (int_event) begin
        int_pend_r <= 1'b1;
        int_cnt_r  <= '0;
      end else if (link.int_ack) begin
        int_pend_r <= 1'b0;
        int_cnt_r  <= '0;
      end else if (int_pend_r) begin
        int_cnt_r  <= int_cnt_r + CNT_W'(1);
      end
    end
  end

  // registered outputs; failsafe keeps everything off for minimum power
  // judged on the next mode so reset falls with the mode change, not after
  wire start_nxt    = (mode_nxt == FSC_STARTUP) | (mode_nxt == FSC_RESTART);
  wire in_reset_out = start_nxt ? in_reset_nxt : 1'b0;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_out_r               <= 1'b0;
      link.int_req            <= 1'b0;
      link.reset_source       <= RSRC_POWER_ON;
      link.mode               <= 3'(FSC_STARTUP);
      mcu_supply_output       <= 1'b0;
      can_tx_enable           <= 1'b0;
      lin_tx_enable           <= 1'b0;
      inhibit_limphome_output <= 1'b0;
      enable_output           <= 1'b0;
    end else if (ce) begin
      rst_out_r <= !(in_reset_out || mode_nxt == FSC_FAILSAFE);
      link.int_req      <= int_pend_r | (running & int_event);
      link.reset_source <= rsrc_nxt;
      link.mode         <= 3'(mode_nxt);
      mcu_supply_output <= (mode_nxt != FSC_FAILSAFE) &&
                           !(mode_nxt == FSC_STARTUP && mode_r ==
                             FSC_FAILSAFE);
      can_tx_enable     <= (mode_nxt == FSC_NORMAL) &
                           link.can_medium_control;
      lin_tx_enable     <= (mode_nxt == FSC_NORMAL) &
                           link.lin_medium_control;
      inhibit_limphome_output <= (mode_nxt == FSC_NORMAL);
      enable_output     <= (mode_nxt == FSC_NORMAL);
    end
  end
  assign link.system_reset_out_n = rst_out_r;
endmodule : fsc_device

//--- rtl/fsc_pkg.sv
// package of constants and types shared by the mode controller and its host
package fsc_pkg;
  // timing figures in ns and the clock period
  localparam int unsigned CLK_PERIOD_NS      = 40;
  localparam int unsigned RST_SHORT_NS       = 1000000;  // default lengthening
  localparam int unsigned RST_LONG_NS        = 20000000; // longer lengthening
  localparam int unsigned RESTART_DELAY_NS   = 2000000;  // fail-safe restart
  localparam int unsigned INT_RESP_NS        = 256000000;
  localparam int unsigned WD_INIT_NS         = 256000000;
  // derived cycle counts; least times round up
  localparam int unsigned RST_SHORT_CYC =
    (RST_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_LONG_CYC =
    (RST_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESTART_CYC =
    (RESTART_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest times round down
  localparam int unsigned INT_RESP_CYC = INT_RESP_NS / CLK_PERIOD_NS;
  localparam int unsigned WD_INIT_CYC  = WD_INIT_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W        = 24;
  // reset source codes
  localparam logic [3:0] RSRC_POWER_ON  = 4'h0;
  localparam logic [3:0] RSRC_WAKE      = 4'h1;
  localparam logic [3:0] RSRC_WD_FAIL   = 4'h2;
  localparam logic [3:0] RSRC_INT_TMO   = 4'h3;
  localparam logic [3:0] RSRC_RESTART   = 4'h4;
  localparam logic [3:0] RSRC_FAILSAFE  = 4'h5;
  localparam logic [3:0] RSRC_EXT_RESET = 4'h6;
  // requested operating mode from host
  typedef enum logic {
    FSC_SEL_NORMAL,
    FSC_SEL_FLASH
  } fsc_sel_type;
  typedef enum logic [2:0] {
    FSC_STARTUP,
    FSC_RESTART,
    FSC_FAILSAFE,
    FSC_NORMAL,
    FSC_FLASH
  } fsc_mode_type;
endpackage : fsc_pkg

//--- rtl/fsc_link_if.sv
// interface joining the mode controller and the host microcontroller end
`timescale 1ns/1ps
interface fsc_link_if;
  logic             system_reset_out_n;
  logic             int_req;        // interrupt request level to host
  logic [3:0]       reset_source;
  logic [2:0]       mode;
  logic             wd_init_done;   // host pulse: watchdog initialised
  logic             wd_select;      // 0 normal, 1 flash
  logic             int_ack;        // host pulse: interrupt register read
  logic             can_medium_control;
  logic             lin_medium_control;
  modport device (
    output system_reset_out_n, int_req, reset_source, mode,
    input  wd_init_done, wd_select, int_ack,
           can_medium_control, lin_medium_control
  );
  modport host (
    input  system_reset_out_n, int_req, reset_source, mode,
    output wd_init_done, wd_select, int_ack,
           can_medium_control, lin_medium_control
  );
endinterface : fsc_link_if

//--- rtl/fsc_sync.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module fsc_sync (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic d,
  output logic      q
);
  logic meta_r;
  // first flop feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : fsc_sync

//--- rtl/fsc_host.sv
// host microcontroller end: watchdog init, interrupt reads, medium control
`timescale 1ns/1ps
module fsc_host
  import fsc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  fsc_link_if.host  link,
  input  wire logic want_flash,
  input  wire logic want_can,
  input  wire logic want_lin,
  output logic      host_running,
  output logic [3:0] last_reset_source
);
  logic rst_s, int_s, rst_d_r, init_r, ack_r, sel_r, can_r, lin_r;
  logic [2:0] mode_s;
  fsc_sync u_sync_rst (.clk(clk), .rst_b(rst_b), .ce(ce),
                       .d(link.system_reset_out_n), .q(rst_s));
  fsc_sync u_sync_int (.clk(clk), .rst_b(rst_b), .ce(ce),
                       .d(link.int_req), .q(int_s));
  // mode code is stable long before it is read; synced bitwise anyway
  for (genvar i = 0; i < 3; i++) begin : g_mode
    fsc_sync u_sync_m (.clk(clk), .rst_b(rst_b), .ce(ce),
                       .d(link.mode[i]), .q(mode_s[i]));
  end
  wire rst_rise  = rst_s & !rst_d_r;
  wire in_restart = (mode_s == 3'(FSC_RESTART));

  // one init pulse after each reset release; ack each interrupt at once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_d_r <= 1'b0;
      init_r  <= 1'b0;
      ack_r   <= 1'b0;
      sel_r   <= 1'b0;
      can_r   <= 1'b0;
      lin_r   <= 1'b0;
      host_running      <= 1'b0;
      last_reset_source <= RSRC_POWER_ON;
    end else if (ce) begin
      rst_d_r <= rst_s;
      init_r  <= rst_rise;
      sel_r   <= want_flash & !in_restart;
      ack_r   <= int_s & !ack_r;
      can_r   <= want_can & rst_s;
      lin_r   <= want_lin & rst_s;
      host_running <= rst_s;
      if (rst_rise) begin
        last_reset_source <= link.reset_source;
      end
    end
  end
  assign link.wd_init_done       = init_r;
  assign link.wd_select          = sel_r;
  assign link.int_ack            = ack_r;
  assign link.can_medium_control = can_r;
  assign link.lin_medium_control = lin_r;
endmodule : fsc_host

//--- tb/fsc_link_assertions.sv
// checker of the link between the mode controller and the host end
`timescale 1ns/1ps
module fsc_link_assertions
  import fsc_pkg::*;
#(
  parameter int unsigned RST_SHORT = 8,
  parameter int unsigned RST_LONG  = 16,
  parameter int unsigned INT_RESP  = 20,
  parameter int unsigned WD_INIT   = 40
) (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       system_reset_out_n,
  input wire logic       int_req,
  input wire logic [3:0] reset_source,
  input wire logic [2:0] mode,
  input wire logic       wd_init_done,
  input wire logic       wd_select,
  input wire logic       int_ack
);
  logic [7:0] low_cnt_r;
  logic [7:0] irq_cnt_r;
  logic [7:0] wait_cnt_r;
  wire        init_wait = (mode == FSC_STARTUP || mode == FSC_RESTART)
                          && system_reset_out_n && !wd_init_done;
  // long counts live in counters since repetitions stop at eight
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_r  <= 8'h00;
      irq_cnt_r  <= 8'h00;
      wait_cnt_r <= 8'h00;
    end else begin
      low_cnt_r  <= system_reset_out_n ? 8'h00
                                       : low_cnt_r + {7'h0, ~&low_cnt_r};
      irq_cnt_r  <= (int_req && system_reset_out_n && !int_ack) ?
                    irq_cnt_r + 8'h01 : 8'h00;
      wait_cnt_r <= init_wait ? wait_cnt_r + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_src_stable: assert property (
    system_reset_out_n && $past(system_reset_out_n) |-> $stable(reset_source))
    else $error("reset source moved while running");
  a_startup_length: assert property (
    $rose(system_reset_out_n) && mode == FSC_STARTUP
    |-> low_cnt_r >= RST_SHORT - 1)
    else $error("start-up reset too short");
  a_lengthen_ends: assert property (
    $fell(system_reset_out_n) && mode == FSC_STARTUP
    |-> ##[1:24] (system_reset_out_n || mode != FSC_STARTUP))
    else $error("reset output never released");
  a_init_normal: assert property (
    wd_init_done && system_reset_out_n && !wd_select && mode == FSC_STARTUP
    |-> ##[1:2] mode == FSC_NORMAL)
    else $error("init did not enter normal");
  a_restart_long: assert property (
    $rose(system_reset_out_n) && mode == FSC_RESTART
    |-> low_cnt_r >= RST_LONG - 1)
    else $error("restart reset too short");
  a_restart_normal: assert property (
    wd_init_done && system_reset_out_n && mode == FSC_RESTART
    |-> ##[1:2] mode == FSC_NORMAL)
    else $error("restart did not enter normal");
  a_failsafe_low: assert property (
    mode == FSC_FAILSAFE |-> !system_reset_out_n)
    else $error("reset released in fail-safe");
  a_failsafe_exit: assert property (
    mode == FSC_FAILSAFE ##1 mode != FSC_FAILSAFE |-> mode == FSC_STARTUP)
    else $error("fail-safe left wrongly");
  a_irq_limit: assert property (
    irq_cnt_r <= INT_RESP + 3)
    else $error("unanswered interrupt kept running");
  a_init_bound: assert property (
    wait_cnt_r <= WD_INIT + 3)
    else $error("watchdog init wait unbounded");
  // main paths seen at least once
  c_restart: cover property (mode == FSC_RESTART);
  c_failsafe: cover property (mode == FSC_FAILSAFE ##1 mode == FSC_STARTUP);
  c_irq_ack: cover property (int_req && int_ack);
endmodule : fsc_link_assertions

//--- tb/testbench.sv
// self-checking bench for the mode controller and host ends together
`timescale 1ns/1ps
module testbench;
  import fsc_pkg::*;
  localparam int unsigned RS = 8, RL = 16, RD = 8, IR = 20, WI = 40;
  logic clk, rst_b, host_ce, len_sel, osc_ok, supply_ok, severe_fault;
  logic can_wake, lin_wake, local_wake, wd_fail, int_event;
  logic want_flash, want_can, want_lin, host_running, dev_ce;
  logic mcu_supply_output, can_tx_enable, lin_tx_enable;
  logic inhibit_limphome_output, enable_output;
  logic [3:0] last_src;
  int bad_count, total_checks, seed;
  fsc_link_if link ();
  fsc_device #(.RST_SHORT(RS), .RST_LONG(RL), .RESTART_D(RD),
    .INT_RESP(IR), .WD_INIT(WI)) fsc_device_i (
    .clk(clk), .rst_b(rst_b), .ce(dev_ce), .link(link),
    .reset_length_select(len_sel), .can_wake(can_wake),
    .lin_wake(lin_wake), .local_wake(local_wake), .osc_ok(osc_ok),
    .supply_ok(supply_ok), .severe_fault(severe_fault),
    .wd_fail(wd_fail), .int_event(int_event),
    .mcu_supply_output(mcu_supply_output), .can_tx_enable(can_tx_enable),
    .lin_tx_enable(lin_tx_enable), .enable_output(enable_output),
    .inhibit_limphome_output(inhibit_limphome_output));
  fsc_host fsc_host_i (.clk(clk), .rst_b(rst_b), .ce(host_ce),
    .link(link), .want_flash(want_flash), .want_can(want_can),
    .want_lin(want_lin), .host_running(host_running),
    .last_reset_source(last_src));
  fsc_link_assertions #(.RST_SHORT(RS), .RST_LONG(RL), .INT_RESP(IR),
    .WD_INIT(WI)) fsc_link_assertions_i (.clk(clk), .rst_b(rst_b),
    .system_reset_out_n(link.system_reset_out_n), .int_req(link.int_req),
    .reset_source(link.reset_source), .mode(link.mode),
    .wd_init_done(link.wd_init_done), .wd_select(link.wd_select),
    .int_ack(link.int_ack));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // bounded wait so a stuck mode shows as a mismatch, not a hang
  task automatic wait_mode(input fsc_mode_type m, input int lim);
    int i;
    i = 0;
    while (link.mode !== m && i < lim) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk(8'(link.mode), 8'(m));
  endtask : wait_mode
  // wakes are synchronised inside, so they are held several cycles
  task automatic wake(input logic [2:0] w);
    @(posedge clk) {local_wake, lin_wake, can_wake} <= w;
    cyc(4);
    {local_wake, lin_wake, can_wake} <= 3'h0;
  endtask : wake
  function automatic logic tx_exp(input logic want, input logic [2:0] m);
    return want && (m == FSC_NORMAL);
  endfunction : tx_exp
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  // guard well past the expected run of under a thousand cycles
  initial begin
    cyc(20000);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    {rst_b, len_sel, wd_fail, int_event, severe_fault} = 5'h00;
    {can_wake, lin_wake, local_wake, want_can, want_lin} = 5'h00;
    {dev_ce, host_ce, osc_ok, supply_ok, want_flash} = 5'h1f;
    bad_count = 0;
    total_checks = 0;
    seed = $urandom(58352);
    cyc(3);
    rst_b <= 1'b1;
    cyc(2);
    #1 chk(8'(link.system_reset_out_n), 8'h00);
    wait_mode(FSC_FLASH, 60);
    // a second power-on reset in mid-run, normal selected this time
    @(posedge clk) rst_b <= 1'b0;
    want_flash <= 1'b0;
    cyc(3);
    rst_b <= 1'b1;
    wait_mode(FSC_NORMAL, 80);
    chk(8'(last_src), 8'(RSRC_POWER_ON));
    chk(8'(host_running), 8'h01);
    chk(8'(enable_output & inhibit_limphome_output), 8'h01);
    chk(8'(can_tx_enable | lin_tx_enable), 8'h00);
    // frozen device ignores a watchdog failure and holds its outputs
    @(posedge clk) dev_ce <= 1'b0;
    wd_fail <= 1'b1;
    @(posedge clk) wd_fail <= 1'b0;
    cyc(2);
    dev_ce <= 1'b1;
    #1 chk(8'(link.mode), 8'(FSC_NORMAL));
    chk(8'(enable_output), 8'h01);
    // random medium requests and answered interrupts
    for (int k = 0; k < 12; k++) begin
      @(posedge clk);
      want_can <= 1'($urandom);
      want_lin <= 1'($urandom);
      int_event <= 1'($urandom);
      len_sel <= 1'($urandom);
      @(posedge clk) int_event <= 1'b0;
      cyc(5 + $urandom_range(20));
      #1 chk(8'(can_tx_enable), 8'(tx_exp(want_can, FSC_NORMAL)));
      chk(8'(lin_tx_enable), 8'(tx_exp(want_lin, FSC_NORMAL)));
      chk(8'(link.mode), 8'(FSC_NORMAL));
    end
    @(posedge clk) wd_fail <= 1'b1;
    @(posedge clk) wd_fail <= 1'b0;
    wait_mode(FSC_STARTUP, 4);
    wait_mode(FSC_NORMAL, 80);
    chk(8'(last_src), 8'(RSRC_WD_FAIL));
    // frozen host: interrupt times out, then restart, then fail-safe
    @(posedge clk) host_ce <= 1'b0;
    @(posedge clk) int_event <= 1'b1;
    @(posedge clk) int_event <= 1'b0;
    cyc(IR - 4);
    #1 chk(8'(link.mode), 8'(FSC_NORMAL));
    wait_mode(FSC_STARTUP, 10);
    chk(8'(link.reset_source), 8'(RSRC_INT_TMO));
    wait_mode(FSC_RESTART, 120);
    wait_mode(FSC_FAILSAFE, 120);
    chk(8'(mcu_supply_output), 8'h00);
    @(posedge clk) osc_ok <= 1'b0;
    wake(3'h1);
    cyc(30);
    #1 chk(8'(link.mode), 8'(FSC_FAILSAFE));
    @(posedge clk) osc_ok <= 1'b1;
    cyc(4);
    wake(3'h2);
    #1 chk(8'(link.mode), 8'(FSC_FAILSAFE));
    wait_mode(FSC_STARTUP, RD + 10);
    @(posedge clk) host_ce <= 1'b1;
    wait_mode(FSC_NORMAL, 80);
    // restart entered with flash asked for must still end in normal
    @(posedge clk) host_ce <= 1'b0;
    want_flash <= 1'b1;
    @(posedge clk) wd_fail <= 1'b1;
    @(posedge clk) wd_fail <= 1'b0;
    wait_mode(FSC_RESTART, 120);
    @(posedge clk) host_ce <= 1'b1;
    wait_mode(FSC_NORMAL, 80);
    @(posedge clk) want_flash <= 1'b0;
    severe_fault <= 1'b1;
    @(posedge clk) severe_fault <= 1'b0;
    wait_mode(FSC_FAILSAFE, 3);
    wake(3'h4);
    wait_mode(FSC_NORMAL, 120);
    tally_and_finish();
  end
endmodule : testbench
